// ==== include/ptr_interp_pkg.sv ====
// Package for the pointer interpreter: codes, layouts, counts and states.
// Assumes one pointer word per frame strobe, both pointer bytes together.
package ptr_interp_pkg;

	// ==========================================================
	// Sizes and counts
	localparam int          OFFSET_W       = 10;
	localparam int          CNT_W          = 4;
	localparam logic [3:0]  NDF_CNT_LIMIT  = 4'h8;
	localparam logic [3:0]  AIS_CNT_LIMIT  = 4'h3;
	localparam logic [3:0]  INV_CNT_LIMIT  = 4'h8;
	localparam logic [3:0]  NEW_CNT_LIMIT  = 4'h3;
	localparam logic [3:0]  CONC_CNT_LIMIT = 4'h3;
	localparam logic [15:0] ALL_ONES       = 16'hffff;
	localparam logic [9:0]  CONC_TAIL      = 10'h3ff;

	// ==========================================================
	// Size bit codes
	localparam logic [1:0] SIZE_WIDE   = 2'h2;
	localparam logic [1:0] SIZE_NARROW = 2'h0;

	// ==========================================================
	// Legal offset ranges per unit type
	localparam logic [9:0] MAX_OFF_AU4  = 10'h30a;
	localparam logic [9:0] MAX_OFF_TU3  = 10'h2fc;
	localparam logic [9:0] MAX_OFF_TU2  = 10'h1ab;
	localparam logic [9:0] MAX_OFF_TU12 = 10'h08b;

	// Fixed stuff value checked at positions two and three of an AU-4 pointer
	localparam logic [7:0] AU4_FIXED_Y = 8'hff;

	typedef enum logic [1:0] {
		UNIT_AU4  = 2'h0,
		UNIT_TU3  = 2'h1,
		UNIT_TU2  = 2'h2,
		UNIT_TU12 = 2'h3
	} unit_type_e;

	typedef enum logic [2:0] {
		ST_NORM  = 3'h0,
		ST_AIS   = 3'h1,
		ST_LOST  = 3'h2,
		ST_INC   = 3'h3,
		ST_DEC   = 3'h4,
		ST_NDF   = 3'h5
	} ptr_state_e;

	typedef enum logic [1:0] {
		CST_CONC  = 2'h0,
		CST_ALARM = 2'h1,
		CST_LOST  = 2'h2
	} conc_state_e;

	// Received pointer: flag, size bits, offset with I/D bits interleaved
	typedef struct packed {
		logic [3:0] ndf;
		logic [1:0] size;
		logic [9:0] offset;
	} ptr_word_s;

	// Classified events of one pointer word
	typedef struct packed {
		logic ndf_on;
		logic ndf_off;
		logic size_ok;
		logic all_ones;
		logic inc;
		logic dec;
		logic in_range;
		logic same_off;
	} ptr_event_s;

	// Flag decode, shared by main and member interpreters
	function automatic logic ndf_enabled(input logic [3:0] f);
		return (f == 4'h9) || (f == 4'h1) || (f == 4'hd) || (f == 4'hb) || (f == 4'h8);
	endfunction

	function automatic logic ndf_disabled(input logic [3:0] f);
		return (f == 4'h6) || (f == 4'he) || (f == 4'h2) || (f == 4'h4) || (f == 4'h7);
	endfunction

	function automatic logic [1:0] size_expect(input unit_type_e t);
		return (t == UNIT_TU2) ? SIZE_NARROW : SIZE_WIDE;
	endfunction

	function automatic logic [9:0] max_offset(input unit_type_e t);
		case (t)
			UNIT_AU4: return MAX_OFF_AU4;
			UNIT_TU3: return MAX_OFF_TU3;
			UNIT_TU2: return MAX_OFF_TU2;
			default:  return MAX_OFF_TU12;
		endcase
	endfunction

	// Majority of five bits
	function automatic logic major5(input logic [4:0] b);
		return (3'(b[0]) + 3'(b[1]) + 3'(b[2]) + 3'(b[3]) + 3'(b[4])) >= 3'h3;
	endfunction

endpackage

// ==== rtl/ptr_classifier.sv ====
// Pointer word classifier: one word in, event flags out (combinational).
// Assumes the active offset and provisioning come from the same clock domain.
`timescale 1ns/1ns
module ptr_classifier
	import ptr_interp_pkg::*;
(
	input  wire ptr_interp_pkg::ptr_word_s   word,
	input  wire ptr_interp_pkg::unit_type_e  unit_type,
	input  wire logic                        ignore_size,
	input  wire logic                        y_ok,
	input  wire logic [9:0]                  active_off,
	output      ptr_interp_pkg::ptr_event_s  ev
);
	import ptr_interp_pkg::*;

	logic [4:0] i_bits;
	logic [4:0] d_bits;
	logic [4:0] i_ref;
	logic [4:0] d_ref;

	always_comb begin
		// I bits sit at odd positions from the top, D bits at even
		i_bits = {word.offset[9], word.offset[7], word.offset[5], word.offset[3], word.offset[1]};
		d_bits = {word.offset[8], word.offset[6], word.offset[4], word.offset[2], word.offset[0]};
		i_ref  = {active_off[9], active_off[7], active_off[5], active_off[3], active_off[1]};
		d_ref  = {active_off[8], active_off[6], active_off[4], active_off[2], active_off[0]};
		ev.ndf_on   = ndf_enabled(word.ndf);
		ev.ndf_off  = ndf_disabled(word.ndf);
		ev.size_ok  = (word.size == size_expect(unit_type));
		if (ignore_size && unit_type == UNIT_AU4)
			ev.size_ok = 1'b1;
		if (unit_type == UNIT_AU4 && !y_ok)
			ev.size_ok = 1'b0;
		ev.all_ones = (word == ALL_ONES);
		ev.in_range = (word.offset <= max_offset(unit_type));
		ev.same_off = (word.offset == active_off);
		ev.inc = ev.ndf_off && ev.size_ok && major5(i_bits ^ i_ref) && !major5(d_bits ^ d_ref);
		ev.dec = ev.ndf_off && ev.size_ok && major5(d_bits ^ d_ref) && !major5(i_bits ^ i_ref);
	end

endmodule // ptr_classifier

// ==== rtl/concat_member.sv ====
// Concatenation indicator interpreter for one member of a concatenated group.
// Assumes frame_tick is a one-cycle strobe in the mclk domain.
`timescale 1ns/1ns
module concat_member
	import ptr_interp_pkg::*;
(
	input  wire logic                        mclk,
	input  wire logic                        rst,
	input  wire logic                        frame_tick,
	input  wire ptr_interp_pkg::ptr_word_s   word,
	output      ptr_interp_pkg::conc_state_e state_q
);
	import ptr_interp_pkg::*;

	conc_state_e state_d;
	logic [3:0]  ci_cnt_q, ci_cnt_d;
	logic [3:0]  ais_cnt_q, ais_cnt_d;
	logic [3:0]  inv_cnt_q, inv_cnt_d;
	logic        ci_ev, ais_ev;

	always_comb begin
		ci_ev  = ndf_enabled(word.ndf) && (word.offset == CONC_TAIL);
		ais_ev = (word == ALL_ONES);
		state_d   = state_q;
		ci_cnt_d  = ci_cnt_q;
		ais_cnt_d = ais_cnt_q;
		inv_cnt_d = inv_cnt_q;
		if (frame_tick) begin
			ci_cnt_d  = ci_ev  ? ((ci_cnt_q  < CONC_CNT_LIMIT) ? ci_cnt_q + 4'h1 : ci_cnt_q) : 4'h0;
			ais_cnt_d = ais_ev ? ((ais_cnt_q < AIS_CNT_LIMIT) ? ais_cnt_q + 4'h1 : ais_cnt_q) : 4'h0;
			inv_cnt_d = (!ci_ev && !ais_ev) ?
				((inv_cnt_q < INV_CNT_LIMIT) ? inv_cnt_q + 4'h1 : inv_cnt_q) : 4'h0;
			if (ais_cnt_d == AIS_CNT_LIMIT && state_q != CST_ALARM)
				state_d = CST_ALARM;
			else if (ci_cnt_d == CONC_CNT_LIMIT && state_q != CST_CONC)
				state_d = CST_CONC;
			else if (inv_cnt_d == INV_CNT_LIMIT && state_q != CST_LOST)
				state_d = CST_LOST;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q   <= CST_LOST;
			ci_cnt_q  <= 4'h0;
			ais_cnt_q <= 4'h0;
			inv_cnt_q <= 4'h0;
		end else begin
			state_q   <= state_d;
			ci_cnt_q  <= ci_cnt_d;
			ais_cnt_q <= ais_cnt_d;
			inv_cnt_q <= inv_cnt_d;
		end
	end

endmodule // concat_member

// ==== rtl/sdh_pointer_interpreter.sv ====
// Receive pointer interpreter with concatenated group defect reporting.
// Assumes a frame aligner delivers pointer words and a one-cycle frame strobe on mclk.
`timescale 1ns/1ns
// Overview of operation
// - Six states: normal, alarm, lost, inc, dec, flag
// - Enabled flag: 1001 0001 1101 1011 1000
// - Disabled flag: 0110 1110 0010 0100 0111
// - Other six flag codes give invalid
// - Normal: disabled, size ok, same offset
// - Flag event: enabled, size ok, in range
// - Alarm event: both bytes all ones
// - Increment: I-bit majority inverted, D not
// - Decrement: D-bit majority inverted, I not
// - Invalid otherwise; inc/dec valid only normal
// - Three equal new offsets fire; also invalid
// - Three new offsets win, clear invalid count
// - New-offset count cleared on most changes
// - Invalid count runs always, kept across changes except new-offset accepts
// - Alarm count never cleared by transitions
// - Flag count cleared only alarm to flag
// - Type mismatch persistently ends in lost
// - AU kinds told apart by fixed bytes
// - Optional size bit bypass for AU
// - AU-4 pointer bytes at positions one, four
// - Member indicator: enabled flag plus pattern
// - Member machine: concat, alarm, lost states
// - Group reports one combined defect
// - Size bits 10 wide, 00 for TU-2
module sdh_pointer_interpreter
	import ptr_interp_pkg::*;
#(
	parameter int MEMBERS = 4
)
(
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       frame_tick,
	input  wire logic [7:0]                 ptr_byte1,
	input  wire logic [7:0]                 ptr_byte2,
	input  wire logic [7:0]                 fixed_byte2,
	input  wire logic [7:0]                 fixed_byte3,
	input  wire ptr_interp_pkg::ptr_word_s  member_word [MEMBERS],
	input  wire ptr_interp_pkg::unit_type_e unit_type,
	input  wire logic                       ignore_size,
	input  wire logic                       concat_en,
	output      ptr_interp_pkg::ptr_state_e state_q,
	output      logic [9:0]                 active_off_q,
	output      logic                       offset_jump_q,
	output      logic                       pointer_lost_q,
	output      logic                       alarm_q,
	output      logic                       group_alarm_defect_q,
	output      logic                       group_lost_defect_q,
	output      logic                       group_normal_state_q
);
	import ptr_interp_pkg::*;

	// ==========================================================
	// Word assembly and classification
	ptr_word_s  word;
	ptr_event_s ev;
	logic       y_ok;

	// Pointer bytes one and four form the word
	assign word = {ptr_byte1, ptr_byte2};
	assign y_ok = (fixed_byte2 == AU4_FIXED_Y) && (fixed_byte3 == AU4_FIXED_Y);

	ptr_classifier u_class (
		.word        (word),
		.unit_type   (unit_type),
		.ignore_size (ignore_size),
		.y_ok        (y_ok),
		.active_off  (active_off_q),
		.ev          (ev)
	);

	// ==========================================================
	// Event derivation
	logic norm_ev, ndf_ev, new_ev, inv_ev, incdec_ok;

	always_comb begin
		norm_ev   = ev.ndf_off && ev.size_ok && ev.same_off;
		ndf_ev    = ev.ndf_on && ev.size_ok && ev.in_range;
		new_ev    = ev.ndf_off && ev.size_ok && ev.in_range && !ev.same_off;
		incdec_ok = (ev.inc || ev.dec) && (state_q == ST_NORM);
		inv_ev    = !norm_ev && !ndf_ev && !ev.all_ones && !incdec_ok;
	end

	// ==========================================================
	// Main state machine and counters
	ptr_state_e state_d;
	logic [9:0] active_off_d, new_off_q, new_off_d;
	logic [3:0] ndf_cnt_q, ndf_cnt_d, ais_cnt_q, ais_cnt_d;
	logic [3:0] inv_cnt_q, inv_cnt_d, new_cnt_q, new_cnt_d;
	logic       jump_d, fire_new, fire_ais, fire_inv, fire_ndf8, keep_new;

	function automatic logic [3:0] bump(input logic [3:0] c, input logic [3:0] lim);
		return (c < lim) ? c + 4'h1 : c;
	endfunction

	always_comb begin
		state_d      = state_q;
		active_off_d = active_off_q;
		new_off_d    = new_off_q;
		ndf_cnt_d    = ndf_cnt_q;
		ais_cnt_d    = ais_cnt_q;
		inv_cnt_d    = inv_cnt_q;
		new_cnt_d    = new_cnt_q;
		jump_d       = 1'b0;
		fire_new     = 1'b0;
		fire_ais     = 1'b0;
		fire_inv     = 1'b0;
		fire_ndf8    = 1'b0;
		keep_new     = 1'b0;
		if (frame_tick) begin
			ndf_cnt_d = ndf_ev ? bump(ndf_cnt_q, NDF_CNT_LIMIT) : 4'h0;
			ais_cnt_d = ev.all_ones ? bump(ais_cnt_q, AIS_CNT_LIMIT) : 4'h0;
			// Invalid count advances in all states
			inv_cnt_d = inv_ev ? bump(inv_cnt_q, INV_CNT_LIMIT) : 4'h0;
			if (new_ev) begin
				new_off_d = word.offset;
				new_cnt_d = (new_cnt_q != 4'h0 && word.offset == new_off_q) ?
					bump(new_cnt_q, NEW_CNT_LIMIT) : 4'h1;
			end else
				new_cnt_d = 4'h0;
			fire_new  = (new_cnt_d == NEW_CNT_LIMIT);
			fire_ais  = (ais_cnt_d == AIS_CNT_LIMIT);
			fire_inv  = (inv_cnt_d == INV_CNT_LIMIT);
			fire_ndf8 = (ndf_cnt_d == NDF_CNT_LIMIT);
			// New offsets win, clear invalid count
			if (fire_new) begin
				inv_cnt_d    = 4'h0;
				new_cnt_d    = 4'h0;
				active_off_d = word.offset;
				jump_d       = 1'b1;
				state_d      = ST_NORM;
			end else if (fire_ais && state_q != ST_AIS) begin
				state_d = ST_AIS;
			end else if (fire_inv && state_q != ST_LOST) begin
				state_d = ST_LOST;
			end else begin
				case (state_q)
					ST_NORM, ST_INC, ST_DEC, ST_NDF: begin
						// Single events drive flag, inc, dec
						if (ndf_ev) begin
							state_d      = ST_NDF;
							active_off_d = word.offset;
							jump_d       = 1'b1;
						end else if (state_q == ST_NORM && ev.inc) begin
							state_d      = ST_INC;
							active_off_d = (active_off_q >= max_offset(unit_type)) ?
								10'h000 : active_off_q + 10'h001;
						end else if (state_q == ST_NORM && ev.dec) begin
							state_d      = ST_DEC;
							active_off_d = (active_off_q == 10'h000) ?
								max_offset(unit_type) : active_off_q - 10'h001;
						end else if (state_q != ST_NORM) begin
							state_d = ST_NORM;
						end
					end
					ST_AIS, ST_LOST: begin
						if (fire_ndf8) begin
							state_d      = ST_NDF;
							active_off_d = word.offset;
							jump_d       = 1'b1;
						end
					end
					default: state_d = ST_LOST;
				endcase
			end
			// New-offset count cleared on most changes
			keep_new = (state_q == ST_NORM && (state_d == ST_INC || state_d == ST_DEC ||
				state_d == ST_NDF)) || (state_d == ST_NORM && (state_q == ST_INC ||
				state_q == ST_DEC || state_q == ST_NDF));
			if (state_d != state_q && !keep_new)
				new_cnt_d = 4'h0;
			// Alarm count is left untouched here
			// Flag count cleared only alarm to flag
			if (state_q == ST_AIS && state_d == ST_NDF)
				ndf_cnt_d = 4'h0;
		end
	end

	// Reset clears counters and enters lost
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q       <= ST_LOST;
			active_off_q  <= 10'h000;
			new_off_q     <= 10'h000;
			ndf_cnt_q     <= 4'h0;
			ais_cnt_q     <= 4'h0;
			inv_cnt_q     <= 4'h0;
			new_cnt_q     <= 4'h0;
			offset_jump_q <= 1'b0;
		end else begin
			state_q       <= state_d;
			active_off_q  <= active_off_d;
			new_off_q     <= new_off_d;
			ndf_cnt_q     <= ndf_cnt_d;
			ais_cnt_q     <= ais_cnt_d;
			inv_cnt_q     <= inv_cnt_d;
			new_cnt_q     <= new_cnt_d;
			offset_jump_q <= jump_d;
		end
	end

	// ==========================================================
	// Concatenated members
	conc_state_e mstate [MEMBERS];

	for (genvar m = 1; m < MEMBERS; m++) begin : g_member
		concat_member u_member (
			.mclk       (mclk),
			.rst        (rst),
			.frame_tick (frame_tick),
			.word       (member_word[m]),
			.state_q    (mstate[m])
		);
	end
	assign mstate[0] = CST_CONC;

	// ==========================================================
	// Combined defect reporting
	logic all_conc, all_alarm, grp_alarm_d, grp_norm_d, grp_lost_d;

	always_comb begin
		all_conc  = 1'b1;
		all_alarm = 1'b1;
		for (int m = 1; m < MEMBERS; m++) begin
			all_conc  = all_conc && (mstate[m] == CST_CONC);
			all_alarm = all_alarm && (mstate[m] == CST_ALARM);
		end
		grp_alarm_d = concat_en && state_d == ST_AIS && all_alarm;
		grp_norm_d  = concat_en && all_conc && state_d == ST_NORM;
		// Increment, decrement and flag groups are no defect either
		grp_lost_d  = concat_en && !grp_alarm_d && !(all_conc && (state_d == ST_NORM ||
			state_d == ST_INC || state_d == ST_DEC || state_d == ST_NDF));
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pointer_lost_q       <= 1'b1;
			alarm_q              <= 1'b0;
			group_alarm_defect_q <= 1'b0;
			group_lost_defect_q  <= 1'b0;
			group_normal_state_q <= 1'b0;
		end else begin
			pointer_lost_q       <= (state_d == ST_LOST);
			alarm_q              <= (state_d == ST_AIS);
			group_alarm_defect_q <= grp_alarm_d;
			group_lost_defect_q  <= grp_lost_d;
			group_normal_state_q <= grp_norm_d;
		end
	end

endmodule // sdh_pointer_interpreter

// ==== verif/ptr_gen_model.sv ====
// Remote pointer generator model: builds one pointer word per command.
// Assumes the bench holds the command steady across each frame strobe.
`timescale 1ns/1ns
module ptr_gen_model
	import ptr_interp_pkg::*;
(
	input  wire logic [1:0]                kind,
	input  wire logic [9:0]                off,
	input  wire logic [3:0]                ndf,
	input  wire logic [1:0]                size,
	output      ptr_interp_pkg::ptr_word_s word
);
	import ptr_interp_pkg::*;

	always_comb begin
		word = '{ndf: ndf, size: size, offset: off};
		case (kind)
			2'h1: word.offset = off ^ 10'h2aa;
			2'h2: word.offset = off ^ 10'h155;
			2'h3: word = ALL_ONES;
			default: ;
		endcase
	end
endmodule // ptr_gen_model

// ==== verif/sdh_pointer_interpreter_props.sv ====
// Checker for the pointer interpreter, bound to its top module.
// Assumes TU-12 provisioning for the offset checks and concat_en held high.
`timescale 1ns/1ns
module sdh_pointer_interpreter_props
	import ptr_interp_pkg::*;
#(
	parameter int MEMBERS = 4
)
(
	input wire logic                       mclk,
	input wire logic                       rst,
	input wire logic                       frame_tick,
	input wire logic [7:0]                 ptr_byte1,
	input wire logic [7:0]                 ptr_byte2,
	input wire logic [7:0]                 fixed_byte2,
	input wire logic [7:0]                 fixed_byte3,
	input wire ptr_interp_pkg::ptr_word_s  member_word [MEMBERS],
	input wire ptr_interp_pkg::unit_type_e unit_type,
	input wire logic                       ignore_size,
	input wire logic                       concat_en,
	input wire ptr_interp_pkg::ptr_state_e state_q,
	input wire logic [9:0]                 active_off_q,
	input wire logic                       offset_jump_q,
	input wire logic                       pointer_lost_q,
	input wire logic                       alarm_q,
	input wire logic                       group_alarm_defect_q,
	input wire logic                       group_lost_defect_q,
	input wire logic                       group_normal_state_q
);
	import ptr_interp_pkg::*;
	ptr_word_s  w;
	logic [9:0] w_off;
	logic       w_ok;
	logic       w_dis;
	logic [1:0] ais_run_d;
	logic [1:0] ais_run_q;
	assign w = {ptr_byte1, ptr_byte2};
	assign w_off = w.offset;
	assign w_ok = (unit_type == UNIT_TU12) && (w.size == 2'h2);
	assign w_dis = w.ndf inside {4'h6, 4'he, 4'h2, 4'h4, 4'h7};

	// ==========
	// All-ones run length
	always_comb begin
		ais_run_d = ais_run_q;
		if (frame_tick) begin
			ais_run_d = (w != ALL_ONES) ? 2'h0 : (ais_run_q == 2'h3) ? 2'h3 : ais_run_q + 2'h1;
		end
	end
	always_ff @(posedge mclk) begin
		ais_run_q <= rst ? 2'h0 : ais_run_d;
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_reset_lost: assert property (disable iff (1'b0)
		rst |=> state_q == ST_LOST && active_off_q == 10'h0 && pointer_lost_q)
		else $error("reset did not enter pointer lost");
	a_idle_hold: assert property (
		!frame_tick |=> $stable(state_q) && $stable(active_off_q))
		else $error("state moved without a frame strobe");
	a_level_flags: assert property (
		alarm_q == (state_q == ST_AIS) && pointer_lost_q == (state_q == ST_LOST))
		else $error("status levels disagree with state");
	a_ais_three: assert property (
		frame_tick && w == ALL_ONES && ais_run_q >= 2'h2 |=> state_q == ST_AIS)
		else $error("three all-ones words did not give alarm");
	a_flag_accept: assert property (
		frame_tick && w_ok && w.ndf inside {4'h9, 4'h1, 4'hd, 4'hb, 4'h8} && w_off <= 10'd139
		&& state_q inside {ST_NORM, ST_INC, ST_DEC, ST_NDF}
		|=> state_q == ST_NDF && active_off_q == $past(w_off) && offset_jump_q)
		else $error("flag event not accepted");
	a_inc_step: assert property (
		frame_tick && state_q == ST_NORM && w_ok && w_dis && active_off_q < 10'd139
		&& $countones((w_off ^ active_off_q) & 10'h2aa) >= 3
		&& $countones((w_off ^ active_off_q) & 10'h155) < 3
		|=> state_q == ST_INC && active_off_q == $past(active_off_q) + 10'h1)
		else $error("increment not applied");
	a_dec_step: assert property (
		frame_tick && state_q == ST_NORM && w_ok && w_dis && active_off_q > 10'h0
		&& $countones((w_off ^ active_off_q) & 10'h155) >= 3
		&& $countones((w_off ^ active_off_q) & 10'h2aa) < 3
		|=> state_q == ST_DEC && active_off_q == $past(active_off_q) - 10'h1)
		else $error("decrement not applied");
	a_norm_return: assert property (
		frame_tick && w_ok && w_dis && w_off == active_off_q
		&& state_q inside {ST_NORM, ST_INC, ST_DEC, ST_NDF}
		|=> state_q == ST_NORM && $stable(active_off_q))
		else $error("normal pointer did not hold normal state");
	a_jump_cause: assert property (
		offset_jump_q |-> $past(frame_tick))
		else $error("offset jump without a frame strobe");
	a_group_norm: assert property (
		group_normal_state_q |-> state_q == ST_NORM && !group_lost_defect_q)
		else $error("group normal without main normal");
	a_group_alarm: assert property (
		group_alarm_defect_q |-> state_q == ST_AIS && !group_lost_defect_q)
		else $error("group alarm without main alarm");
	a_group_lost: assert property (
		concat_en && !$past(rst) && state_q == ST_LOST |-> group_lost_defect_q)
		else $error("main pointer lost but group not lost");
endmodule // sdh_pointer_interpreter_props

bind sdh_pointer_interpreter sdh_pointer_interpreter_props #(.MEMBERS(MEMBERS)) u_props (
	.mclk(mclk), .rst(rst), .frame_tick(frame_tick), .ptr_byte1(ptr_byte1),
	.ptr_byte2(ptr_byte2), .fixed_byte2(fixed_byte2), .fixed_byte3(fixed_byte3),
	.member_word(member_word), .unit_type(unit_type), .ignore_size(ignore_size),
	.concat_en(concat_en), .state_q(state_q), .active_off_q(active_off_q),
	.offset_jump_q(offset_jump_q), .pointer_lost_q(pointer_lost_q), .alarm_q(alarm_q),
	.group_alarm_defect_q(group_alarm_defect_q), .group_lost_defect_q(group_lost_defect_q),
	.group_normal_state_q(group_normal_state_q));

// ==== verif/sdh_pointer_interpreter_tb_top.sv ====
// Self-checking bench for the pointer interpreter with a pointer generator model.
// Assumes one word per frame strobe and results one cycle after the strobe.
`timescale 1ns/1ns
module sdh_pointer_interpreter_tb_top;
	import ptr_interp_pkg::*;
	localparam int        MEMBERS = 4;
	localparam logic [1:0] K_NORM = 2'h0;
	localparam logic [1:0] K_INC  = 2'h1;
	localparam logic [1:0] K_DEC  = 2'h2;
	localparam logic [1:0] K_AIS  = 2'h3;
	logic       mclk = 1'b0;
	logic       rst = 1'b1;
	logic       frame_tick = 1'b0;
	logic [1:0] gen_kind = 2'h0;
	logic [9:0] gen_off = 10'h0;
	logic [3:0] gen_ndf = 4'h6;
	logic [1:0] gen_size = 2'h2;
	unit_type_e prov_unit = UNIT_TU12;
	logic [7:0] fix2 = 8'hff;
	logic       ign_size = 1'b0;
	ptr_word_s  gen_word;
	ptr_word_s  mw = 16'h9bff;
	ptr_word_s  member_word [MEMBERS];
	ptr_state_e state_q;
	logic [9:0] active_off_q;
	logic       jump, lost, alarm, g_alarm, g_lost, g_norm;
	int         n_tests = 0;
	int         n_mismatch = 0;
	assign member_word = '{default: mw};
	always #2 mclk = ~mclk;

	ptr_gen_model u_ptr_gen_model (.kind(gen_kind), .off(gen_off), .ndf(gen_ndf),
		.size(gen_size), .word(gen_word));
	sdh_pointer_interpreter #(.MEMBERS(MEMBERS)) u_sdh_pointer_interpreter (
		.mclk(mclk), .rst(rst), .frame_tick(frame_tick), .ptr_byte1(gen_word[15:8]),
		.ptr_byte2(gen_word[7:0]), .fixed_byte2(fix2), .fixed_byte3(8'hff),
		.member_word(member_word), .unit_type(prov_unit), .ignore_size(ign_size),
		.concat_en(1'b1), .state_q(state_q), .active_off_q(active_off_q),
		.offset_jump_q(jump), .pointer_lost_q(lost), .alarm_q(alarm),
		.group_alarm_defect_q(g_alarm), .group_lost_defect_q(g_lost),
		.group_normal_state_q(g_norm));

	// ==========
	// Drivers and compares
	task automatic send(input logic [1:0] k, input logic [9:0] o, input logic [3:0] f,
		input logic [1:0] s = 2'h2);
		@(posedge mclk);
		frame_tick <= 1'b1;
		gen_kind <= k;
		gen_off <= o;
		gen_ndf <= f;
		gen_size <= s;
		@(posedge mclk);
		frame_tick <= 1'b0;
		#1;
	endtask
	task automatic cmp_state(input string what, input ptr_state_e exp);
		n_tests++;
		if (state_q !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0d seen %0d", what, exp, state_q);
		end
	endtask
	task automatic cmp_val(input string what, input logic [9:0] exp, input logic [9:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ==========
	// Scenarios
	task automatic t_ais();
		cmp_state("reset state", ST_LOST);
		cmp_val("reset lost flag", 10'h1, 10'(lost));
		@(posedge mclk);
		mw <= ALL_ONES;
		repeat (2) send(K_AIS, 10'h0, 4'h0);
		cmp_state("two all-ones", ST_LOST);
		send(K_AIS, 10'h0, 4'h0);
		cmp_state("three all-ones", ST_AIS);
		cmp_val("alarm flag", 10'h1, 10'(alarm));
		// Member states reach the group outputs one clock later
		@(posedge mclk);
		#1;
		cmp_val("group alarm", 10'h1, 10'(g_alarm));
	endtask
	task automatic t_ndf8();
		@(posedge mclk);
		mw <= 16'h9bff;
		repeat (7) send(K_NORM, 10'd50, 4'h9);
		cmp_state("seven flags", ST_AIS);
		send(K_NORM, 10'd50, 4'h9);
		cmp_state("eight flags", ST_NDF);
		cmp_val("flag offset", 10'd50, active_off_q);
		cmp_val("flag jump", 10'h1, 10'(jump));
		send(K_NORM, 10'd50, 4'h6);
		cmp_state("normal pointer", ST_NORM);
		cmp_val("group normal", 10'h1, 10'(g_norm));
	endtask
	task automatic t_codes();
		logic [3:0] en [5] = '{4'h9, 4'h1, 4'hd, 4'hb, 4'h8};
		logic [3:0] dis [5] = '{4'h6, 4'he, 4'h2, 4'h4, 4'h7};
		for (int i = 0; i < 5; i++) begin
			send(K_NORM, 10'd60 + 10'(i), en[i]);
			cmp_state("enabled code", ST_NDF);
			cmp_val("new offset", 10'd60 + 10'(i), active_off_q);
			send(K_NORM, 10'd60 + 10'(i), dis[i]);
			cmp_state("disabled code", ST_NORM);
		end
	endtask
	task automatic t_incdec();
		send(K_INC, 10'd64, 4'h6);
		cmp_state("increment", ST_INC);
		cmp_val("incremented offset", 10'd65, active_off_q);
		send(K_NORM, 10'd65, 4'h6);
		send(K_DEC, 10'd65, 4'h6);
		cmp_state("decrement", ST_DEC);
		send(K_INC, 10'd64, 4'h6);
		cmp_state("increment outside normal", ST_NORM);
		cmp_val("offset kept", 10'd64, active_off_q);
	endtask
	task automatic t_newpt();
		repeat (2) send(K_NORM, 10'd100, 4'h6);
		cmp_val("two new offsets", 10'd64, active_off_q);
		send(K_NORM, 10'd100, 4'h6);
		cmp_state("three new offsets", ST_NORM);
		cmp_val("accepted offset", 10'd100, active_off_q);
		cmp_val("new offset jump", 10'h1, 10'(jump));
	endtask
	task automatic t_inv();
		logic [3:0] bad [6] = '{4'h0, 4'h3, 4'h5, 4'ha, 4'hc, 4'hf};
		foreach (bad[i]) send(K_NORM, 10'd100, bad[i]);
		send(K_NORM, 10'd100, 4'h6, 2'h0);
		cmp_state("seven invalid", ST_NORM);
		send(K_NORM, 10'd100, 4'h6, 2'h0);
		cmp_state("eight invalid", ST_LOST);
		cmp_val("group lost", 10'h1, 10'(g_lost));
	endtask
	task automatic t_au();
		@(posedge mclk);
		prov_unit <= UNIT_AU4;
		fix2 <= 8'h00;
		repeat (3) send(K_NORM, 10'd200, 4'h6);
		cmp_state("bad fixed bytes", ST_LOST);
		@(posedge mclk);
		fix2 <= 8'hff;
		ign_size <= 1'b1;
		repeat (3) send(K_NORM, 10'd200, 4'h6, 2'h0);
		cmp_state("size bits ignored", ST_NORM);
		cmp_val("unit offset", 10'd200, active_off_q);
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		#1;
		t_ais();
		t_ndf8();
		t_codes();
		t_incdec();
		t_newpt();
		t_inv();
		t_au();
		stop_test();
	end
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		stop_test();
	end
endmodule // sdh_pointer_interpreter_tb_top
